/* core/dwb_pkg.sv */
// Constants shared by the DDR2 write burst capture logic
package dwb_pkg;

	// Command code {cs_n, ras_n, cas_n, we_n} of a WRITE
	localparam logic [3:0] DWB_CMD_WRITE = 4'h4;

	// Address bit that requests auto precharge with a WRITE
	localparam int DWB_PFLAG_POS = 10;

	// Burst lengths in data elements
	localparam logic [3:0] DWB_BL4 = 4'h4;
	localparam logic [3:0] DWB_BL8 = 4'h8;
	// Element boundary on which a long burst may be cut short
	localparam logic [3:0] DWB_TRUNC_AT = 4'h4;

	// Least write latency in clocks that the arming pipe supports
	localparam logic [3:0] DWB_WL_MIN = 4'h2;
	// Clocks subtracted from read latency to give write latency
	localparam logic [3:0] DWB_WL_OFFSET = 4'h1;

	// Depth of the write arming pipe in link clocks
	localparam int DWB_PIPE_DEPTH = 16;

	// Capture sequencer states
	typedef enum logic [2:0] {
		DWB_ST_IDLE = 3'b001,
		DWB_ST_PRE  = 3'b010,
		DWB_ST_DATA = 3'b100
	} dwb_st_e;

endpackage

/* core/dwb_core.sv */
// DDR2 write burst capture: latency, strobe capture, concatenation, auto precharge
//
// Overview of operation
// - Write latency is read latency minus one; code uses two for read latency 1 or 2
// - Read latency is additive plus column latency
// - WRITE gives bank, column; auto precharge closes row
// - Precharge flag bit high selects auto precharge
// - Capture on first strobe rise, then every edge
// - After burst, data lines idle and input ignored
// - Next WRITE half a burst later streams gaplessly
// - Eight burst cut only by WRITE at four
// - Write recovery count sets auto precharge start
// - Each byte lane captured by its own strobe
`timescale 1ns/1ps
`default_nettype none
module dwb_core
	import dwb_pkg::*;
#(
	parameter int LANES  = 2,
	parameter int LANE_W = 8,
	parameter int BA_W   = 3,
	parameter int ADDR_W = 14,
	parameter int COL_W  = 10
)(
	// System clock and reset
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_in,
	// Mode settings, static while bursts run
	input  wire logic [2:0]                cfg_cas_latency_in,
	input  wire logic [2:0]                cfg_additive_latency_in,
	input  wire logic                      cfg_burst8_in,
	input  wire logic [3:0]                cfg_write_recovery_in,
	// Link clock and command pins
	input  wire logic                      ck_in,
	input  wire logic                      cs_n_in,
	input  wire logic                      ras_n_in,
	input  wire logic                      cas_n_in,
	input  wire logic                      we_n_in,
	input  wire logic [BA_W-1:0]           ba_in,
	input  wire logic [ADDR_W-1:0]         addr_in,
	// Data, mask and strobe pins
	input  wire logic [LANES*LANE_W-1:0]   dq_in,
	output logic      [LANES*LANE_W-1:0]   dq_out,
	output logic                           dq_oe_out,
	input  wire logic [LANES-1:0]          dm_in,
	input  wire logic [LANES-1:0]          dqs_in,
	output logic      [LANES-1:0]          dqs_out,
	output logic                           dqs_oe_out,
	// Captured write elements
	output logic                           wvalid_out,
	output logic      [LANES*LANE_W-1:0]   wdata_out,
	output logic      [LANES-1:0]          wmask_out,
	output logic      [BA_W-1:0]           wbank_out,
	output logic      [COL_W-1:0]          wcol_out,
	output logic      [3:0]                welem_out,
	// Auto precharge request and protocol fault
	output logic                           precharge_out,
	output logic      [BA_W-1:0]           precharge_bank_out,
	output logic                           proto_err_out
);
	localparam int DW  = LANES * LANE_W;
	localparam int PW  = $clog2(DWB_PIPE_DEPTH);
	localparam int CW  = 4 + BA_W + ADDR_W + DW + LANES + LANES;
	typedef struct packed {
		logic             ap;
		logic [BA_W-1:0]  bank;
		logic [COL_W-1:0] col;
	} dwb_rec_s;
	typedef struct packed {
		// Synchronisers: first stage, second stage, previous sample
		logic [CW:0]                    in_m;
		logic [CW:0]                    in_s;
		logic                           ck_o;
		logic [LANES-1:0]               dqs_o;
		// Arming pipe of accepted WRITE commands
		logic [DWB_PIPE_DEPTH-1:0]      pv;
		dwb_rec_s [DWB_PIPE_DEPTH-1:0]  pr;
		// Next armed burst and the burst in progress
		logic                           nxt_v;
		dwb_rec_s                       nxt;
		dwb_rec_s                       cur;
		dwb_st_e                        st;
		logic [3:0]                     ecnt;
		logic [LANES-1:0]               have;
		logic [DW-1:0]                  data;
		logic [LANES-1:0]               mask;
		// Auto precharge countdown
		logic                           ap_busy;
		logic [3:0]                     ap_cnt;
		logic [BA_W-1:0]                ap_bank;
		// Registered outputs
		logic                           wvalid;
		logic [DW-1:0]                  wdata;
		logic [LANES-1:0]               wmask;
		logic [BA_W-1:0]                wbank;
		logic [COL_W-1:0]               wcol;
		logic [3:0]                     welem;
		logic                           pre;
		logic [BA_W-1:0]                pre_bank;
		logic                           err;
	} dwb_state_s;
	dwb_state_s s_q;
	dwb_state_s s_d;
	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic              ck_rise;
		logic [3:0]        cmd;
		logic [BA_W-1:0]   ba;
		logic [ADDR_W-1:0] addr;
		logic [DW-1:0]     dq;
		logic [LANES-1:0]  dm;
		logic [LANES-1:0]  dqs;
		logic [3:0]        rl;
		logic [3:0]        wl;
		logic [3:0]        bl;
		logic [PW-1:0]     ins;
		dwb_rec_s          rec;
		logic              done;
		s_d = s_q;
		s_d.wvalid = 1'b0;
		s_d.pre = 1'b0;
		s_d.err = 1'b0;
		done = 1'b0;
		// Every pin passes two flops before use
		s_d.in_m = {ck_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, ba_in,
			addr_in, dq_in, dm_in, dqs_in};
		s_d.in_s = s_q.in_m;
		{ck_rise, cmd, ba, addr, dq, dm, dqs} = s_q.in_s;
		s_d.ck_o = ck_rise;
		s_d.dqs_o = dqs;
		ck_rise = ck_rise & ~s_q.ck_o;
		rl = 4'(cfg_additive_latency_in) + 4'(cfg_cas_latency_in);
		wl = rl - DWB_WL_OFFSET;
		if (wl < DWB_WL_MIN)
			wl = DWB_WL_MIN;
		bl = cfg_burst8_in ? DWB_BL8 : DWB_BL4;
		// Armed one clock early so an early strobe is not missed
		ins = PW'(wl - DWB_WL_MIN);
		// record bank, column and precharge choice
		rec.bank = ba;
		rec.col = addr[COL_W-1:0];
		rec.ap = addr[DWB_PFLAG_POS];
		if (ck_rise)
		begin
			// burst armed one clock before write latency after command
			if (s_q.pv[0])
			begin
				if (s_q.nxt_v)
					s_d.err = 1'b1;
				s_d.nxt_v = 1'b1;
				s_d.nxt = s_q.pr[0];
			end
			s_d.pv = {1'b0, s_q.pv[DWB_PIPE_DEPTH-1:1]};
			s_d.pr[DWB_PIPE_DEPTH-2:0] = s_q.pr[DWB_PIPE_DEPTH-1:1];
			if (cmd == DWB_CMD_WRITE)
			begin
				s_d.pv[ins] = 1'b1;
				s_d.pr[ins] = rec;
			end
			if (s_q.ap_busy)
			begin
				if (s_q.ap_cnt == 4'h0)
				begin
					s_d.ap_busy = 1'b0;
					s_d.pre = 1'b1;
					s_d.pre_bank = s_q.ap_bank;
				end
				else
					s_d.ap_cnt = s_q.ap_cnt - 4'h1;
			end
		end
		case (s_q.st)
			DWB_ST_IDLE:
			begin
				// strobes and data ignored while idle
				s_d.have = '0;
				if (s_d.nxt_v)
				begin
					s_d.cur = s_d.nxt;
					s_d.nxt_v = 1'b0;
					s_d.ecnt = 4'h0;
					s_d.st = DWB_ST_PRE;
				end
			end
			DWB_ST_PRE, DWB_ST_DATA:
			begin
				for (int l = 0; l < LANES; l++)
				begin
					// each lane on its own strobe
					// first rising edge, then every edge
					if ((dqs[l] ^ s_q.dqs_o[l]) && !s_q.have[l] &&
						(s_q.st == DWB_ST_DATA || dqs[l]))
					begin
						s_d.have[l] = 1'b1;
						s_d.data[l*LANE_W +: LANE_W] = dq[l*LANE_W +: LANE_W];
						s_d.mask[l] = dm[l];
					end
				end
				if (&s_d.have)
				begin
					s_d.have = '0;
					s_d.st = DWB_ST_DATA;
					s_d.wvalid = 1'b1;
					s_d.wdata = s_d.data;
					s_d.wmask = s_d.mask;
					s_d.wbank = s_q.cur.bank;
					s_d.wcol = s_q.cur.col;
					s_d.welem = s_q.ecnt;
					s_d.ecnt = s_q.ecnt + 4'h1;
					if (s_d.ecnt == bl)
					begin
						done = 1'b1;
						// close the row after the full burst
						if (s_q.cur.ap)
						begin
							if (s_q.ap_busy)
								s_d.err = 1'b1;
							s_d.ap_busy = 1'b1;
							s_d.ap_cnt = cfg_write_recovery_in;
							s_d.ap_bank = s_q.cur.bank;
						end
					end
					else if (s_d.ecnt == DWB_TRUNC_AT && s_d.nxt_v)
					begin
						// cut only long bursts without precharge
						// a short burst is never cut
						if (cfg_burst8_in && !s_q.cur.ap)
							done = 1'b1;
						else
							s_d.err = 1'b1;
					end
					if (done)
					begin
						// next burst follows with no gap
						if (s_d.nxt_v)
						begin
							s_d.cur = s_d.nxt;
							s_d.nxt_v = 1'b0;
							s_d.ecnt = 4'h0;
							s_d.st = DWB_ST_PRE;
						end
						else
							s_d.st = DWB_ST_IDLE;
					end
				end
			end
			default:
				s_d.st = DWB_ST_IDLE;
		endcase
	end
	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s_q <= '0;
			s_q.st <= DWB_ST_IDLE;
		end
		else
			s_q <= s_d;
	end
	////////////////////////////////////////////////////////////////////////
	// Outputs
	// write path never drives the data or strobe pins
	assign dq_out = '0;
	assign dq_oe_out = 1'b0;
	assign dqs_out = '0;
	assign dqs_oe_out = 1'b0;
	assign wvalid_out = s_q.wvalid;
	assign wdata_out = s_q.wdata;
	assign wmask_out = s_q.wmask;
	assign wbank_out = s_q.wbank;
	assign wcol_out = s_q.wcol;
	assign welem_out = s_q.welem;
	assign precharge_out = s_q.pre;
	assign precharge_bank_out = s_q.pre_bank;
	assign proto_err_out = s_q.err;
endmodule
`default_nettype wire

/* dv/dwb_props.sv */
// Port checker for the write burst capture core
`timescale 1ns/1ps
`default_nettype none
module dwb_props #(parameter int W = 16)(
	input wire logic         sys_clk_in,
	input wire logic         rst_in,
	input wire logic         cfg_burst8_in,
	input wire logic [W-1:0] dq_out,
	input wire logic         dq_oe_out,
	input wire logic [1:0]   dqs_out,
	input wire logic         dqs_oe_out,
	input wire logic         wvalid_out,
	input wire logic [3:0]   welem_out,
	input wire logic         precharge_out,
	input wire logic         proto_err_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	logic [3:0] last_q;
	always_ff @(posedge sys_clk_in)
		if (rst_in)
			last_q <= 4'h0;
		else if (wvalid_out)
			last_q <= welem_out;
	// Strobe edges are half a link clock apart, far above three cycles
	sequence s_gap;
		!wvalid_out [*3];
	endsequence
	a_dq_idle: assert property (!dq_oe_out && dq_out == '0)
		else $error("dq driven");
	a_dqs_idle: assert property (!dqs_oe_out && dqs_out == '0)
		else $error("dqs driven");
	a_elem_gap: assert property (wvalid_out |=> s_gap)
		else $error("elements too close");
	a_elem_next: assert property (wvalid_out && welem_out != 4'h0
		|-> welem_out == last_q + 4'h1) else $error("element skipped");
	a_burst_wrap: assert property (wvalid_out &&
		last_q == (cfg_burst8_in ? 4'h7 : 4'h3) |-> welem_out == 4'h0)
		else $error("burst not restarted");
	a_elem_bound: assert property (wvalid_out |->
		welem_out < (cfg_burst8_in ? 4'h8 : 4'h4)) else $error("burst long");
	a_pre_pulse: assert property (precharge_out |=> !precharge_out)
		else $error("precharge held");
	a_err_pulse: assert property (proto_err_out |=> !proto_err_out)
		else $error("fault held");
	cover property (precharge_out);
endmodule
bind dwb_core dwb_props #(.W(LANES*LANE_W)) dwb_props_inst (.sys_clk_in,
	.rst_in, .cfg_burst8_in, .dq_out, .dq_oe_out, .dqs_out, .dqs_oe_out,
	.wvalid_out, .welem_out, .precharge_out, .proto_err_out);
`default_nettype wire

/* dv/dwb_ctl_model.sv */
// Behavioural memory controller issuing write bursts
`timescale 1ns/1ps
`default_nettype none
module dwb_ctl_model
	import dwb_pkg::*;
(
	// Link clock and command pins
	output logic        ck_out,
	output logic [3:0]  cmd_n_out,
	output logic [2:0]  ba_out,
	output logic [13:0] addr_out,
	// Data, mask and strobe pins
	output logic [17:0] dmdq_out,
	output logic [1:0]  dqs_out
);
	event last_ev;
	initial
	begin
		ck_out = 1'b0;
		cmd_n_out = 4'hf;
		ba_out = 3'h0;
		addr_out = 14'h0;
		dmdq_out = 18'h0;
		dqs_out = 2'h0;
		#3;
		forever #80 ck_out = ~ck_out;
	end
	task automatic write(input logic [2:0] b, input logic [9:0] c,
		input logic ap, input int n, input int wl, input logic [17:0] e [8]);
		@(negedge ck_out);
		cmd_n_out = DWB_CMD_WRITE;
		ba_out = b;
		addr_out = {3'h0, ap, c};
		@(negedge ck_out);
		cmd_n_out = 4'hf;
		ba_out = ~ba_out;
		addr_out = ~addr_out;
		fork
			data(n, wl, e);
		join_none
	endtask
	task automatic data(input int n, input int wl, input logic [17:0] e [8]);
		repeat (wl - 1) @(posedge ck_out);
		@(negedge ck_out);
		for (int k = 0; k < n; k++)
		begin
			#40;
			dmdq_out = e[k];
			#40;
			dqs_out = ~dqs_out;
		end
		#20;
		dmdq_out = ~dmdq_out;
		-> last_ev;
	endtask
	task automatic stray();
		#40;
		dqs_out = ~dqs_out;
		#80;
		dqs_out = ~dqs_out;
	endtask
endmodule
`default_nettype wire

/* dv/dwb_core_tb.sv */
// Self-checking bench for the write burst capture core
`timescale 1ns/1ps
`default_nettype none
module dwb_core_tb;
	logic        sys_clk_in, rst_in, b8, ck, wvalid, pre, err, err_seen;
	logic [2:0]  cl, al, ba, wbank, pbank;
	logic [3:0]  wr, cmd_n, welem;
	logic [13:0] addr;
	logic [17:0] dmdq;
	logic [15:0] wdata;
	logic [1:0]  dqs, wmask;
	logic [9:0]  wcol;
	logic [34:0] exp_q [$];
	int          err_total = 0, tests_run = 0, cycles = 0, ck_cnt = 0, wl;
	dwb_core dwb_core_inst (.sys_clk_in, .rst_in, .cfg_cas_latency_in(cl),
		.cfg_additive_latency_in(al), .cfg_burst8_in(b8),
		.cfg_write_recovery_in(wr), .ck_in(ck), .cs_n_in(cmd_n[3]),
		.ras_n_in(cmd_n[2]), .cas_n_in(cmd_n[1]), .we_n_in(cmd_n[0]),
		.ba_in(ba), .addr_in(addr), .dq_in(dmdq[15:0]), .dq_out(),
		.dq_oe_out(), .dm_in(dmdq[17:16]), .dqs_in(dqs), .dqs_out(),
		.dqs_oe_out(), .wvalid_out(wvalid), .wdata_out(wdata),
		.wmask_out(wmask), .wbank_out(wbank), .wcol_out(wcol),
		.welem_out(welem), .precharge_out(pre),
		.precharge_bank_out(pbank), .proto_err_out(err));
	dwb_ctl_model ctl (.ck_out(ck), .cmd_n_out(cmd_n), .ba_out(ba),
		.addr_out(addr), .dmdq_out(dmdq), .dqs_out(dqs));
	initial
	begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge ck)
		ck_cnt++;
	task automatic chk(input string n, input logic [34:0] e, g);
		tests_run++;
		if (e !== g)
		begin
			err_total++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Sampled mid-cycle so registered outputs have settled
	always @(negedge sys_clk_in)
	begin
		cycles++;
		if (err === 1'b1)
			err_seen = 1'b1;
		if (wvalid === 1'b1)
			chk("elem", exp_q.size() ? exp_q.pop_front() : 35'bx,
				{wbank, wcol, welem, wmask, wdata});
		if (cycles == 40000)
		begin
			err_total++;
			stop_test();
		end
	end
	task setup(input logic [2:0] c, a, input logic b, input logic [3:0] w);
		@(posedge sys_clk_in);
		#1;
		cl = c;
		al = a;
		b8 = b;
		wr = w;
		wl = int'(a) + int'(c) - 1;
	endtask
	task automatic wr_burst(input logic [2:0] b, input logic [9:0] c,
		input logic ap, input int n);
		logic [17:0] e [8];
		for (int k = 0; k < 8; k++)
		begin
			e[k] = 18'($urandom);
			if (k < n)
				exp_q.push_back({b, c, 4'(k), e[k]});
		end
		ctl.write(b, c, ap, n, wl, e);
	endtask
	task automatic pre_chk(input logic [2:0] b);
		int s;
		@(ctl.last_ev);
		s = ck_cnt;
		for (int i = 0; i < 2000 && pre !== 1'b1; i++)
		begin
			@(posedge sys_clk_in);
			#1;
		end
		chk("pre", {b, 32'(wr + 1)}, {pbank, 32'(ck_cnt - s)});
	endtask
	task automatic drain(input string n);
		for (int i = 0; i < 600 && exp_q.size() != 0; i++)
			@(posedge sys_clk_in);
		repeat (300) @(posedge sys_clk_in);
		chk("left", 35'h0, 35'(exp_q.size()));
		chk("fault", 35'h0, {34'h0, err_seen});
		err_seen = 1'b0;
		$display("test %s done", n);
	endtask
	initial
	begin
		logic [2:0] b;
		rst_in = 1'b1;
		err_seen = 1'b0;
		void'($urandom(32'h3604c30e));
		setup(3'h3, 3'h1, 1'b0, 4'h2);
		repeat (5) @(posedge sys_clk_in);
		#1;
		rst_in = 1'b0;
		repeat (4) @(posedge sys_clk_in);
		wr_burst(3'h1, 10'h010, 1'b0, 4);
		drain("single");
		ctl.stray();
		drain("stray");
		wr_burst(3'h2, 10'h100, 1'b0, 4);
		wr_burst(3'h5, 10'h3fe, 1'b0, 4);
		drain("gapless");
		setup(3'h4, 3'h0, 1'b1, 4'h2);
		wr_burst(3'h3, 10'h020, 1'b0, 4);
		wr_burst(3'h6, 10'h040, 1'b1, 8);
		drain("trunc");
		for (int i = 0; i < 4; i++)
		begin
			setup(3'(3 + $urandom % 3), 3'($urandom % 3), 1'($urandom),
				4'(2 + $urandom % 5));
			b = 3'($urandom);
			wr_burst(b, 10'($urandom), 1'b1, b8 ? 8 : 4);
			pre_chk(b);
			drain("autopre");
		end
		stop_test();
	end
endmodule
`default_nettype wire
